// ===== eeprom_host_pkg.sv
// Behaviour
// - Host keeps write enable high for the whole of every read.
// - A page load holds one to 64 bytes in any order.
// - Host holds write enable low at least the minimum write pulse.
// - Host should load successive bytes within the byte-load window.
// - Holding the controlling strobe low inhibits the page-load timer.
// - Host waits the last-load-to-poll delay before polling reads.
package eeprom_host_pkg;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int PAGE_BYTES = 64;
    localparam int IDX_W = 6;

    // ==========================================================
    // Timing, clock 10 MHz
    // ==========================================================
    localparam int CLK_PERIOD_NS = 100;
    // Minimum write pulse, 150 ns, rounded up.
    localparam int MIN_WRITE_PULSE_NS = 150;
    localparam int WP_CYC =
        (MIN_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least gap between byte loads, 0.2 us, rounded up.
    localparam int BYTE_LOAD_MIN_NS = 200;
    localparam int GAP_CYC =
        (BYTE_LOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Byte-load window, 300 us; host must stay well inside it.
    localparam int BYTE_LOAD_WINDOW_US = 300;
    localparam int WINDOW_CYC = BYTE_LOAD_WINDOW_US * 1000 / CLK_PERIOD_NS;
    // Last load to polling, 600 us, an exact 6000 cycles.
    localparam int LAST_LOAD_TO_POLL_DELAY_US = 600;
    localparam int POLL_DELAY_CYC =
        LAST_LOAD_TO_POLL_DELAY_US * 1000 / CLK_PERIOD_NS;
    // Maximum internal write, 10 ms.
    localparam int WRITE_TIME_MS = 10;
    localparam int WRITE_TIME_CYC =
        WRITE_TIME_MS * 1000000 / CLK_PERIOD_NS;
    // Read access 150 ns, rounded up.
    localparam int ACCESS_NS = 150;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 20;

    // ==========================================================
    // States
    // ==========================================================
    typedef enum logic [6:0] {
        ST_IDLE  = 7'b000_0001,
        ST_RD    = 7'b000_0010,
        ST_WLOW  = 7'b000_0100,
        ST_WGAP  = 7'b000_1000,
        ST_PWAIT = 7'b001_0000,
        ST_POLL  = 7'b010_0000,
        ST_PGAP  = 7'b100_0000
    } state_t;

endpackage : eeprom_host_pkg

// ===== page_buffer.sv
`timescale 1ns/1ns
module page_buffer
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [eeprom_host_pkg::IDX_W-1:0] wr_idx,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] wr_data,
    input wire logic [eeprom_host_pkg::IDX_W-1:0] rd_idx,
    output logic [eeprom_host_pkg::DATA_W-1:0] rd_data
);
    import eeprom_host_pkg::*;

    // ==========================================================
    // Page staging store
    // ==========================================================
    logic [DATA_W-1:0] mem_r [PAGE_BYTES];

    // One register per byte; no reset since valid count guards reads.
    genvar g;
    generate
        for (g = 0; g < PAGE_BYTES; g++)
        begin : g_byte
            always_ff @(posedge ref_clk)
            begin
                if (wr_en && wr_idx == IDX_W'(g))
                    mem_r[g] <= wr_data;
            end
        end
    endgenerate

    // Read port is combinational; the caller registers it.
    assign rd_data = mem_r[rd_idx];

endmodule : page_buffer

// ===== eeprom_host.sv
`timescale 1ns/1ns
module eeprom_host
(
    input wire logic ref_clk,
    input wire logic rst,
    // User write side: stage bytes, then commit a page.
    input wire logic load_valid,
    input wire logic [eeprom_host_pkg::IDX_W-1:0] load_offset,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] load_data,
    input wire logic page_commit,
    input wire logic [eeprom_host_pkg::ADDR_W-1:0] page_addr,
    input wire logic [eeprom_host_pkg::IDX_W:0] page_count,
    // User read side.
    input wire logic read_req,
    input wire logic [eeprom_host_pkg::ADDR_W-1:0] read_addr,
    output logic [eeprom_host_pkg::DATA_W-1:0] read_data,
    output logic read_done,
    output logic busy,
    output logic write_done,
    output logic write_timeout,
    // Device pins.
    output logic [eeprom_host_pkg::ADDR_W-1:0] mem_addr,
    output logic chip_sel_n,
    output logic out_en_n,
    output logic write_en_n,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] bidir_data_bus_in,
    output logic [eeprom_host_pkg::DATA_W-1:0] bidir_data_bus_out,
    output logic bidir_data_bus_oe
);
    import eeprom_host_pkg::*;

    // ==========================================================
    // State and registers
    // ==========================================================
    state_t state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] tout_r;
    logic [IDX_W:0] sent_r;
    logic [IDX_W:0] total_r;
    logic [ADDR_W-1:0] page_r;
    logic [DATA_W-1:0] last_data_r;
    logic [ADDR_W-1:0] last_addr_r;
    logic [DATA_W-1:0] buf_q;
    logic [IDX_W-1:0] send_idx;

    page_buffer u_buf
    (
        .ref_clk(ref_clk),
        .wr_en(load_valid && state_r == ST_IDLE),
        .wr_idx(load_offset),
        .wr_data(load_data),
        .rd_idx(send_idx),
        .rd_data(buf_q)
    );

    // ==========================================================
    // Decode
    // ==========================================================
    // Bytes go out in offset order 0..count-1; device accepts any order.
    // Index and page look one step ahead, so that address and data are
    // already right on the edge at which write enable falls; otherwise
    // the device would latch the previous byte's address.
    assign send_idx = (state_r == ST_IDLE) ? '0
        : (state_r == ST_WGAP) ? IDX_W'(sent_r + 1'b1)
        : sent_r[IDX_W-1:0];
    wire [ADDR_W-1:0] wr_page = (state_r == ST_IDLE) ? page_addr : page_r;
    wire cnt_done = (cnt_r == '0);
    wire start_wr = page_commit && page_count != '0
        && page_count <= (IDX_W+1)'(PAGE_BYTES);
    wire more_bytes = (sent_r + 1'b1) < total_r;
    // Polling succeeds when the true byte reads back, not its complement.
    wire poll_ok = (bidir_data_bus_in == last_data_r);
    wire tout_hit = (tout_r == '0);

    // Next-state logic.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start_wr)
                    state_nxt = ST_WLOW;
                else if (read_req)
                    state_nxt = ST_RD;
            ST_RD:
                if (cnt_done)
                    state_nxt = ST_IDLE;
            ST_WLOW:
                if (cnt_done)
                    state_nxt = ST_WGAP;
            ST_WGAP:
                if (cnt_done)
                    state_nxt = more_bytes ? ST_WLOW : ST_PWAIT;
            ST_PWAIT:
                if (cnt_done)
                    state_nxt = ST_POLL;
            ST_POLL:
                if (cnt_done)
                    state_nxt = (poll_ok || tout_hit) ? ST_IDLE : ST_PGAP;
            ST_PGAP:
                state_nxt = ST_POLL;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    // ==========================================================
    // Counters
    // ==========================================================
    // Phase counter reloads on each state entry with that phase's length.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            cnt_r <= '0;
        else if (state_nxt != state_r || state_r == ST_PGAP)
            case (state_nxt)
                ST_RD: cnt_r <= CNT_W'(ACCESS_CYC);
                ST_WLOW: cnt_r <= CNT_W'(WP_CYC);
                ST_WGAP: cnt_r <= CNT_W'(GAP_CYC);
                ST_PWAIT: cnt_r <= CNT_W'(POLL_DELAY_CYC);
                ST_POLL: cnt_r <= CNT_W'(ACCESS_CYC);
                default: cnt_r <= '0;
            endcase
        else if (!cnt_done)
            cnt_r <= cnt_r - 1'b1;
    end

    // Give up polling once the longest internal write has passed.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
            tout_r <= '0;
        else if (state_r == ST_WGAP && state_nxt == ST_PWAIT)
            tout_r <= CNT_W'(WRITE_TIME_CYC);
        else if (!tout_hit)
            tout_r <= tout_r - 1'b1;
    end

    // Byte progress and page bookkeeping.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            sent_r <= '0;
            total_r <= '0;
            page_r <= '0;
        end
        else if (state_r == ST_IDLE && start_wr)
        begin
            sent_r <= '0;
            total_r <= page_count;
            page_r <= page_addr;
        end
        else if (state_r == ST_WGAP && state_nxt == ST_WLOW)
            sent_r <= sent_r + 1'b1;
    end

    // ==========================================================
    // Pin drive
    // ==========================================================
    // Select stays low through a page; write enable is the controlling
    // strobe, so the device latches address on its fall and data on its
    // rise. Output enable is high for every write and write enable is high
    // for every read.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            chip_sel_n <= 1'b1;
            out_en_n <= 1'b1;
            write_en_n <= 1'b1;
            mem_addr <= '0;
            bidir_data_bus_out <= '0;
            bidir_data_bus_oe <= 1'b0;
        end
        else
        begin
            chip_sel_n <= !(state_nxt == ST_RD || state_nxt == ST_WLOW
                || state_nxt == ST_WGAP || state_nxt == ST_POLL);
            out_en_n <= !(state_nxt == ST_RD || state_nxt == ST_POLL);
            write_en_n <= (state_nxt != ST_WLOW);
            bidir_data_bus_oe <= (state_nxt == ST_WLOW
                || state_nxt == ST_WGAP);
            if (state_nxt == ST_WLOW)
            begin
                // Page bits constant within the page; offset changes.
                mem_addr <= {wr_page[ADDR_W-1:IDX_W], send_idx};
                bidir_data_bus_out <= buf_q;
            end
            else if (state_nxt == ST_RD && state_r == ST_IDLE)
                mem_addr <= read_addr;
            else if (state_nxt == ST_POLL)
                mem_addr <= last_addr_r;
        end
    end

    // Remember last byte for completion polling.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            last_data_r <= '0;
            last_addr_r <= '0;
        end
        else if (state_nxt == ST_WLOW)
        begin
            last_data_r <= buf_q;
            last_addr_r <= {wr_page[ADDR_W-1:IDX_W], send_idx};
        end
    end

    // ==========================================================
    // User status
    // ==========================================================
    // No erase step: the device erases before writing.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            read_data <= '0;
            read_done <= 1'b0;
            busy <= 1'b0;
            write_done <= 1'b0;
            write_timeout <= 1'b0;
        end
        else
        begin
            read_done <= (state_r == ST_RD && cnt_done);
            if (state_r == ST_RD && cnt_done)
                read_data <= bidir_data_bus_in;
            busy <= (state_nxt != ST_IDLE);
            write_done <= (state_r == ST_POLL && cnt_done && poll_ok);
            write_timeout <= (state_r == ST_POLL && cnt_done
                && !poll_ok && tout_hit);
        end
    end

endmodule : eeprom_host

// ===== eeprom_host_checker.sv
`timescale 1ns/1ns
// ==========================================================
// Pin protocol checker
// ==========================================================
module eeprom_host_checker
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic read_req,
    input wire logic page_commit,
    input wire logic [eeprom_host_pkg::IDX_W:0] page_count,
    input wire logic busy,
    input wire logic write_done,
    input wire logic write_timeout,
    input wire logic [eeprom_host_pkg::ADDR_W-1:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [eeprom_host_pkg::DATA_W-1:0] bidir_data_bus_out,
    input wire logic bidir_data_bus_oe
);
    import eeprom_host_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Strobe combinations; a write strobe never overlaps a read.
    chk_write_mode: assert property (!write_en_n |-> !chip_sel_n && out_en_n)
        else $error("write strobe outside write mode");
    chk_read_we_high: assert property (!out_en_n |-> write_en_n)
        else $error("write enable low during read");
    chk_bus_contend: assert property (bidir_data_bus_oe |-> out_en_n)
        else $error("host drives bus while device outputs");
    chk_pulse_width: assert property ($fell(write_en_n) |=> !write_en_n)
        else $error("write pulse shorter than two cycles");
    chk_load_gap: assert property ($rose(write_en_n) |=> write_en_n)
        else $error("gap between byte loads too short");
    chk_addr_data_hold: assert property (
        !write_en_n && !$past(write_en_n)
        |-> $stable(mem_addr) && $stable(bidir_data_bus_out))
        else $error("address or data moved during write pulse");
    chk_page_fixed: assert property (
        !write_en_n && !$past(chip_sel_n) && $past(out_en_n)
        |-> mem_addr[14:6] == $past(mem_addr[14:6]))
        else $error("page bits changed during page load");
    chk_commit_busy: assert property (
        page_commit && !busy && page_count inside {[1:64]} |=> busy)
        else $error("valid commit not taken");
    chk_read_busy: assert property (
        read_req && !busy && !page_commit |=> busy)
        else $error("read request not taken");
    chk_done_excl: assert property (!(write_done && write_timeout))
        else $error("done and timeout together");
    cover property ($rose(write_done));
    cover property (read_req && !busy);
    cover property ($fell(write_en_n));
endmodule : eeprom_host_checker

bind eeprom_host eeprom_host_checker u_eeprom_host_checker (.*);

// ===== eeprom_dev_model.sv
`timescale 1ns/1ns
// ==========================================================
// Device model: page load timer, internal write and polling
// ==========================================================
module eeprom_dev_model
#(
    parameter int WIN = 20,
    parameter int WT = 8000
)
(
    input wire logic ref_clk,
    input wire logic [14:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_en_n,
    input wire logic write_en_n,
    input wire logic [7:0] bus,
    output logic [7:0] dev_q
);
    logic [7:0] mem [0:32767];
    logic [7:0] pend [0:63];
    logic [63:0] pv = '0;
    logic [7:0] last_b = '0, last_q = '0, dbuf = '0;
    logic [8:0] pg = '0;
    logic [5:0] off = '0;
    logic wr_r = 1'b0, loading = 1'b0;
    int tmr = 0, wt = 0;
    wire wr_now = !chip_sel_n && !write_en_n && out_en_n;
    wire rd_now = !chip_sel_n && !out_en_n && write_en_n;
    // Released lines show the inverse so a stale byte never passes.
    assign dev_q = rd_now ? (wt > 0 ? ~last_b : mem[mem_addr]) : ~last_q;
    initial
    begin
        for (int i = 0; i < 32768; i++) mem[i] = i[7:0] ^ 8'h5a;
    end
    // Sampled behaviour of the strobes; writes during busy are dropped.
    always @(posedge ref_clk)
    begin
        wr_r <= wr_now;
        if (rd_now) last_q <= dev_q;
        if (wt > 0) wt <= wt - 1;
        if (wt == 0 && wr_now) dbuf <= bus;
        if (wt == 0 && wr_now && !wr_r)
        begin
            if (!loading) pg <= mem_addr[14:6];
            off <= mem_addr[5:0];
            loading <= 1'b1;
        end
        if (wr_now) tmr <= WIN;
        else if (loading && tmr > 0) tmr <= tmr - 1;
        if (wr_r && !wr_now && loading)
        begin
            pend[off] <= dbuf;
            pv[off] <= 1'b1;
            last_b <= dbuf;
        end
        if (loading && !wr_now && !wr_r && tmr == 1)
        begin
            for (int i = 0; i < 64; i++)
                if (pv[i]) mem[{pg, i[5:0]}] <= pend[i];
            pv <= '0;
            loading <= 1'b0;
            wt <= WT;
        end
    end
endmodule : eeprom_dev_model

// ===== page_write_eeprom_port_tb_top.sv
`timescale 1ns/1ns
// ==========================================================
// Testbench top
// ==========================================================
module page_write_eeprom_port_tb_top;
    import eeprom_host_pkg::*;
    logic ref_clk = 1'b0, rst = 1'b1, load_valid = 1'b0;
    logic page_commit = 1'b0, read_req = 1'b0;
    logic [5:0] load_offset = '0;
    logic [7:0] load_data = '0, read_data, bus_out, dev_q, mir [0:32767];
    logic [14:0] page_addr = '0, read_addr = '0, mem_addr;
    logic [6:0] page_count = '0;
    logic read_done, busy, write_done, write_timeout, oe;
    logic chip_sel_n, out_en_n, write_en_n;
    int n_errors = 0, checks = 0, seed = 32'h3c8012c1;
    // The wire level follows whichever side drives.
    wire [7:0] bus = oe ? bus_out : dev_q;
    always #50 ref_clk = ~ref_clk;
    eeprom_host u_eeprom_host (.ref_clk(ref_clk), .rst(rst),
        .load_valid(load_valid), .load_offset(load_offset),
        .load_data(load_data), .page_commit(page_commit),
        .page_addr(page_addr), .page_count(page_count),
        .read_req(read_req), .read_addr(read_addr), .read_data(read_data),
        .read_done(read_done), .busy(busy), .write_done(write_done),
        .write_timeout(write_timeout), .mem_addr(mem_addr),
        .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .bidir_data_bus_in(bus),
        .bidir_data_bus_out(bus_out), .bidir_data_bus_oe(oe));
    eeprom_dev_model u_eeprom_dev_model (.ref_clk(ref_clk),
        .mem_addr(mem_addr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
        .write_en_n(write_en_n), .bus(bus), .dev_q(dev_q));
    task automatic give_verdict();
        if (n_errors == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Inputs move a fixed 10 ns after each rising edge.
    task automatic tick();
        @(posedge ref_clk);
        #10;
    endtask : tick
    task automatic wait_for(ref logic sig, input int lim);
        int n;
        for (n = 0; n < lim && sig !== 1'b1; n++) tick();
        if (n == lim)
        begin
            chk("wait bound", 0, 1);
            give_verdict();
        end
    endtask : wait_for
    // Stage count random bytes, commit and wait for completion polling.
    task automatic write_page(logic [8:0] pg, int cnt);
        for (int i = 0; i < cnt; i++)
        begin
            load_valid = 1'b1;
            load_offset = i[5:0];
            load_data = 8'($random(seed));
            mir[{pg, i[5:0]}] = load_data;
            tick();
        end
        load_valid = 1'b0;
        page_commit = 1'b1;
        page_addr = {pg, 6'h00};
        page_count = cnt[6:0];
        tick();
        page_commit = 1'b0;
        wait_for(write_done, 20000);
        chk("timeout", write_timeout, 0);
        tick();
    endtask : write_page
    task automatic read_at(logic [14:0] a);
        read_req = 1'b1;
        read_addr = a;
        tick();
        read_req = 1'b0;
        wait_for(read_done, 50);
        chk("read_data", read_data, mir[a]);
        tick();
    endtask : read_at
    // Main sequence.
    initial
    begin
        for (int i = 0; i < 32768; i++) mir[i] = i[7:0] ^ 8'h5a;
        repeat (5) tick();
        rst = 1'b0;
        chk("idle strobes", {chip_sel_n, out_en_n, write_en_n, oe}, 4'he);
        foreach (page_count[k])
        begin
            page_count = k[0] ? 7'd0 : 7'd65;
            page_commit = 1'b1;
            tick();
            page_commit = 1'b0;
            tick();
            chk("busy refused", busy, 0);
        end
        write_page(9'h0a5, 64);
        for (int i = 0; i < 64; i += 9) read_at({9'h0a5, i[5:0]});
        write_page(9'h0a5, 1);
        read_at({9'h0a5, 6'h00});
        read_at({9'h0a5, 6'h3f});
        for (int i = 0; i < 6; i++) read_at(15'($random(seed)));
        give_verdict();
    end
endmodule : page_write_eeprom_port_tb_top
